// ### pcdb_framer.sv
// Our own choices: the Wishbone register port and the register offsets.
`include "pcdb_defines.svh"

// Contract
// RQ1 - Checksum generated and checked only while checksum_enable is set.
// RQ2 - Transmit appends two checksum bytes after the last payload byte.
// RQ3 - Receive compares computed and received checksum, sets checksum_pass_flag.
// RQ4 - On mismatch by default flush the queue and withhold payload available.
// RQ5 - With checksum_flush_disable set, keep data and still raise payload available.
// RQ6 - Received checksum bytes never enter the queue.
// RQ7 - Variant 0: 0x1021, seed 1D0F, inverted; 1: 0x8005, seed FFFF, plain.
// RQ8 - Manchester and whitening are never active together.
// RQ9 - Shaping code 01 selects Manchester, only in packet mode.
// RQ10 - Manchester sends one as chips 10 and zero as 01.
// RQ11 - Coding covers payload and checksum only, preamble and sync stay plain.
// RQ12 - One chip per chip tick throughout; Manchester halves payload bit rate.
// RQ13 - Shaping code 10 whitens transmit and de-whitens receive at full rate.
// RQ14 - Whitening sequence from 9-bit LFSR, polynomial x^9 + x^5 + 1.
// RQ15 - Payload and both checksum bytes are XORed with the sequence.
// RQ16 - Host sees plain bytes; all coding happens between queue and line.
// RQ17 - Repeat mode restores queue contents and flags on leaving transmit; code restores read pointer and count only, flags keep their value.
// RQ18 - Host uses repeat mode with fixed length below queue size only.
// RQ19 - Leaving repeat: clear enable, write one to overflow flag, queue empties.
// RQ20 - Payload queue holds 64 bytes.
// RQ21 - Whitening register reloads all ones at each packet start.
// RQ22 - Checksum register loads the selected seed at each packet start.
module pcdb_framer
	import pcdb_pkg::*;
#(
	parameter int DEPTH = 64, // see RQ20
	parameter int AW    = 6
)(
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Transmit chip stream
	input  wire logic        chip_tick,
	input  wire logic        tx_start,
	output logic             tx_chip,
	output logic             tx_chip_valid,
	output logic             tx_done,
	// Receive chip stream
	input  wire logic        rx_start,
	input  wire logic        rx_chip,
	input  wire logic        rx_chip_valid,
	// Events
	output logic             payload_available_irq
);

	pcdb_cfg_s   cfg;
	pcdb_state_e st_q;
	logic [31:0] ctrl_q;
	logic [7:0]  len_q;
	logic [7:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr_q, rd_ptr_q, snap_ptr_q;
	logic [AW:0] cnt_q, snap_cnt_q;
	logic        snap_vld_q, tx_en_prev_q;
	logic        ovf_q, pass_q, avail_q, ack_q;
	logic [7:0]  sh_q, crc_lo_q;
	logic [2:0]  bit_q;
	logic        half_q, first_q, tx_done_q, tx_chip_q, tx_vld_q;
	logic [8:0]  byte_q, tot;
	logic        man, wht, full, empty;
	logic        req, acc, hit_fifo, bus_push, bus_pop, w1c_ovf, w1c_avail;
	logic        tx_acc, rx_acc, chip_go, rx_go, tx_bit, line_bit, rx_bit, rx_data;
	logic        eng_init, eng_step, eng_bit, in_pay, byte_end, last_byte;
	logic        link_push, link_pop, push, pop, push_req, flush, restore;
	logic        rx_fin, crc_match, fail_drop;
	logic [7:0]  rx_byte, pop_data, push_data;
	logic [15:0] crc_q, crc_d, tx_fin, rx_fin_crc;
	logic [8:0]  lfsr_q;
	logic        white;

	function automatic logic [31:0] sel_mask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	assign cfg = '{
		crc_en:    ctrl_q[`PCDB_CTRL_CRC_EN],
		flush_dis: ctrl_q[`PCDB_CTRL_FLUSH],
		variant:   ctrl_q[`PCDB_CTRL_VAR],
		shape:     ctrl_q[`PCDB_CTRL_SHP_HI:`PCDB_CTRL_SHP_LO],
		repeat_en: ctrl_q[`PCDB_CTRL_REPEAT],
		tx_en:     ctrl_q[`PCDB_CTRL_TX_EN],
		rx_en:     ctrl_q[`PCDB_CTRL_RX_EN],
		pkt_mode:  ctrl_q[`PCDB_CTRL_PKT],
		lvl:       ctrl_q[`PCDB_CTRL_LVL_HI:`PCDB_CTRL_LVL_LO]
	};

	// Code 11 decodes to neither scheme
	assign man = (cfg.shape == `PCDB_SHAPE_MANCH) && cfg.pkt_mode; // see RQ8 see RQ9
	assign wht = (cfg.shape == `PCDB_SHAPE_WHITE); // see RQ13

	assign full  = (cnt_q == (AW+1)'(DEPTH));
	assign empty = (cnt_q == '0);

	// Bus decode; queue access waits while the link uses the queue
	assign req       = wb_cyc_i && wb_stb_i;
	assign hit_fifo  = (wb_adr_i == `PCDB_ADR_FIFO);
	assign acc       = ce && req && !ack_q && !(hit_fifo && (link_push || link_pop));
	assign bus_push  = acc && hit_fifo && wb_we_i && wb_sel_i[0]; // see RQ16
	assign bus_pop   = acc && hit_fifo && !wb_we_i;
	assign w1c_ovf   = acc && wb_we_i && wb_sel_i[0] && (wb_adr_i == `PCDB_ADR_STAT)
		&& wb_dat_i[`PCDB_ST_OVF];
	assign w1c_avail = acc && wb_we_i && wb_sel_i[0] && (wb_adr_i == `PCDB_ADR_STAT)
		&& wb_dat_i[`PCDB_ST_AVAIL];

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			ack_q <= 1'b0;
		else if (ce)
			ack_q <= acc;
	end

	assign wb_ack_o = ack_q;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			wb_dat_o <= 32'h0000_0000;
		else if (acc && !wb_we_i)
		begin
			if (wb_adr_i == `PCDB_ADR_CTRL)
				wb_dat_o <= ctrl_q;
			else if (wb_adr_i == `PCDB_ADR_LEN)
				wb_dat_o <= {24'h00_0000, len_q};
			else if (hit_fifo)
				wb_dat_o <= {24'h00_0000, pop_data};
			else if (wb_adr_i == `PCDB_ADR_STAT)
				wb_dat_o <= {17'h0_0000, cnt_q, 2'h0, avail_q, pass_q, ovf_q,
					(cnt_q > {1'b0, cfg.lvl}), full, empty};
			else
				wb_dat_o <= 32'h0000_0000;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q <= `PCDB_CTRL_RESET;
			len_q  <= `PCDB_LEN_RESET;
		end
		else if (acc && wb_we_i)
		begin
			if (wb_adr_i == `PCDB_ADR_CTRL)
				ctrl_q <= (ctrl_q & ~sel_mask(wb_sel_i)) | (wb_dat_i & sel_mask(wb_sel_i));
			else if (wb_adr_i == `PCDB_ADR_LEN && wb_sel_i[0])
				len_q <= wb_dat_i[7:0];
		end
	end

	// Packet sequencing
	assign tot       = {1'b0, len_q} + (cfg.crc_en ? 9'h002 : 9'h000); // see RQ1
	assign tx_acc    = ce && st_q == PCDB_IDLE && tx_start && cfg.tx_en && tot != 9'h000;
	assign rx_acc    = ce && st_q == PCDB_IDLE && !tx_acc && rx_start && cfg.rx_en
		&& tot != 9'h000;
	assign eng_init  = tx_acc || rx_acc;
	assign chip_go   = ce && st_q == PCDB_TX && chip_tick; // see RQ12
	assign rx_go     = ce && st_q == PCDB_RX && rx_chip_valid;
	assign tx_bit    = sh_q[7];
	assign line_bit  = wht ? tx_bit ^ white : tx_bit; // see RQ15
	assign rx_bit    = wht ? rx_chip ^ white : rx_chip; // see RQ15
	assign rx_data   = (man && half_q) ? first_q : rx_bit;
	assign eng_step  = (chip_go || rx_go) && (!man || half_q);
	assign eng_bit   = (st_q == PCDB_TX) ? tx_bit : rx_data;
	assign in_pay    = byte_q < {1'b0, len_q};
	assign byte_end  = eng_step && bit_q == 3'h7;
	assign last_byte = byte_q == tot - 9'h001;
	assign rx_byte   = {sh_q[6:0], rx_data};
	assign tx_fin    = cfg.variant ? crc_d : ~crc_d; // see RQ7
	assign rx_fin_crc = cfg.variant ? crc_q : ~crc_q; // see RQ7
	assign link_push = byte_end && st_q == PCDB_RX && in_pay; // see RQ6
	assign link_pop  = (tx_acc && len_q != 8'h00)
		|| (byte_end && st_q == PCDB_TX && byte_q + 9'h001 < {1'b0, len_q});
	assign rx_fin    = byte_end && st_q == PCDB_RX && last_byte;
	assign crc_match = rx_fin_crc == {crc_lo_q, rx_byte}; // see RQ3
	assign fail_drop = rx_fin && cfg.crc_en && !crc_match && !cfg.flush_dis; // see RQ4

	pcdb_code_engine u_engine (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.ce        (ce),
		.init      (eng_init),
		.variant   (cfg.variant),
		.step      (eng_step),
		.crc_step  (in_pay && cfg.crc_en),
		.data_bit  (eng_bit),
		.crc_q     (crc_q),
		.crc_d     (crc_d),
		.lfsr_q    (lfsr_q),
		.white_bit (white)
	);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			st_q <= PCDB_IDLE;
		else if (ce)
		begin
			case (st_q)
				PCDB_IDLE:
					if (tx_acc)
						st_q <= PCDB_TX;
					else if (rx_acc)
						st_q <= PCDB_RX;
				PCDB_TX:
					if (!cfg.tx_en || (byte_end && last_byte))
						st_q <= PCDB_END;
				PCDB_RX:
					if (!cfg.rx_en || rx_fin)
						st_q <= PCDB_END;
				default:
					st_q <= PCDB_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sh_q     <= 8'h00;
			bit_q    <= 3'h0;
			half_q   <= 1'b0;
			first_q  <= 1'b0;
			byte_q   <= 9'h000;
			crc_lo_q <= 8'h00;
		end
		else if (eng_init)
		begin
			sh_q   <= pop_data;
			bit_q  <= 3'h0;
			half_q <= 1'b0;
			byte_q <= 9'h000;
		end
		else if (chip_go || rx_go)
		begin
			if (man)
				half_q <= !half_q; // see RQ12
			if (rx_go && !half_q)
				first_q <= rx_bit;
			if (eng_step)
			begin
				bit_q <= bit_q + 3'h1;
				sh_q  <= (st_q == PCDB_RX) ? rx_byte : {sh_q[6:0], 1'b0};
			end
			if (byte_end)
			begin
				byte_q <= byte_q + 9'h001;
				if (st_q == PCDB_RX && byte_q == {1'b0, len_q})
					crc_lo_q <= rx_byte;
				else if (st_q == PCDB_TX && byte_q + 9'h001 < {1'b0, len_q})
					sh_q <= pop_data;
				else if (st_q == PCDB_TX && byte_q + 9'h001 == {1'b0, len_q})
				begin
					sh_q     <= tx_fin[15:8]; // see RQ2
					crc_lo_q <= tx_fin[7:0];
				end
				else if (st_q == PCDB_TX)
					sh_q <= crc_lo_q;
			end
		end
	end

	// Chips leave only inside the payload and checksum window
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_chip_q <= 1'b0;
			tx_vld_q  <= 1'b0;
			tx_done_q <= 1'b0;
		end
		else if (ce)
		begin
			tx_vld_q  <= chip_go; // see RQ11
			tx_done_q <= chip_go && byte_end && last_byte;
			if (chip_go)
				tx_chip_q <= (man && half_q) ? !line_bit : line_bit; // see RQ10
		end
	end

	assign tx_chip       = tx_chip_q;
	assign tx_chip_valid = tx_vld_q;
	assign tx_done       = tx_done_q;

	// Status flags; a hardware set wins over a software clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pass_q  <= 1'b0;
			avail_q <= 1'b0;
			ovf_q   <= 1'b0;
		end
		else if (ce)
		begin
			if (rx_fin && cfg.crc_en)
				pass_q <= crc_match; // see RQ1 see RQ3
			if (rx_fin && !fail_drop)
				avail_q <= 1'b1; // see RQ5
			else if (w1c_avail)
				avail_q <= 1'b0;
			if (push_req && full)
				ovf_q <= 1'b1;
			else if (w1c_ovf)
				ovf_q <= 1'b0;
		end
	end

	assign payload_available_irq = avail_q;

	// Payload queue
	assign push_req  = link_push || bus_push;
	assign push_data = link_push ? rx_byte : wb_dat_i[7:0];
	assign push      = push_req && !full;
	assign pop       = (link_pop || bus_pop) && !empty;
	assign pop_data  = mem[rd_ptr_q];
	assign flush     = fail_drop || w1c_ovf; // see RQ4 see RQ19
	assign restore   = ce && tx_en_prev_q && !cfg.tx_en && cfg.repeat_en && snap_vld_q;

	always_ff @(posedge sys_clk)
	begin
		if (ce && push)
			mem[wr_ptr_q] <= push_data;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end
		else if (ce)
		begin
			if (flush)
			begin
				wr_ptr_q <= '0;
				rd_ptr_q <= '0;
				cnt_q    <= '0;
			end
			else if (restore)
			begin
				rd_ptr_q <= snap_ptr_q; // see RQ17
				cnt_q    <= snap_cnt_q;
			end
			else
			begin
				if (push)
					wr_ptr_q <= wr_ptr_q + AW'(1);
				if (pop)
					rd_ptr_q <= rd_ptr_q + AW'(1);
				cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
			end
		end
	end

	// Snapshot at frame start lets the same payload be resent
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			snap_ptr_q   <= '0;
			snap_cnt_q   <= '0;
			snap_vld_q   <= 1'b0;
			tx_en_prev_q <= 1'b0;
		end
		else if (ce)
		begin
			tx_en_prev_q <= cfg.tx_en;
			if (flush || restore)
				snap_vld_q <= 1'b0;
			if (tx_acc && cfg.repeat_en && !snap_vld_q)
			begin
				snap_ptr_q <= rd_ptr_q; // see RQ17
				snap_cnt_q <= cnt_q;
				snap_vld_q <= 1'b1;
			end
		end
	end

	sequence s_rx_fail;
		rx_fin && cfg.crc_en && !crc_match;
	endsequence

	a_one_shaping: assert property (@(posedge sys_clk) disable iff (rst) // see RQ8
		!(man && wht))
		else $error("both shaping schemes active");

	a_flush_fail: assert property (@(posedge sys_clk) disable iff (rst) // see RQ4
		(s_rx_fail and !cfg.flush_dis and !avail_q) |=> empty && !avail_q)
		else $error("failed packet kept or announced");

	a_keep_fail: assert property (@(posedge sys_clk) disable iff (rst) // see RQ5
		(s_rx_fail and cfg.flush_dis) |=> avail_q && !pass_q)
		else $error("failed packet not announced");

	a_crc_off: assert property (@(posedge sys_clk) disable iff (rst) // see RQ1
		(rx_fin && !cfg.crc_en) |=> $stable(pass_q) && avail_q)
		else $error("pass flag moved with checksum off");

	a_strip_crc: assert property (@(posedge sys_clk) disable iff (rst) // see RQ6
		(rx_go && byte_end && !in_pay && !bus_push && !restore) |=> cnt_q <= $past(cnt_q))
		else $error("checksum byte pushed to queue");

	a_manch_pair: assert property (@(posedge sys_clk) disable iff (rst) // see RQ10
		(chip_go && man && half_q) |=> tx_chip_q != $past(tx_chip_q))
		else $error("manchester chip pair not complementary");

	a_chip_rate: assert property (@(posedge sys_clk) disable iff (rst) // see RQ12
		tx_chip_valid |-> $past(chip_tick) && $past(ce))
		else $error("chip issued without a chip tick");

	a_beacon_back: assert property (@(posedge sys_clk) disable iff (rst) // see RQ17
		restore && !flush |=> cnt_q == $past(snap_cnt_q) && rd_ptr_q == $past(snap_ptr_q))
		else $error("queue not restored after repeat frame");

	a_exit_flush: assert property (@(posedge sys_clk) disable iff (rst) // see RQ19
		w1c_ovf |=> empty ##1 (cnt_q <= (AW+1)'(1)))
		else $error("queue not emptied on overflow clear");

endmodule // pcdb_framer

// ### pcdb_defines.svh
`ifndef PCDB_DEFINES_SVH
`define PCDB_DEFINES_SVH

// Register byte addresses
`define PCDB_ADR_CTRL     8'h00
`define PCDB_ADR_LEN      8'h04
`define PCDB_ADR_FIFO     8'h08
`define PCDB_ADR_STAT     8'h0C

// Control register fields
`define PCDB_CTRL_CRC_EN  0
`define PCDB_CTRL_FLUSH   1
`define PCDB_CTRL_VAR     2
`define PCDB_CTRL_SHP_LO  3
`define PCDB_CTRL_SHP_HI  4
`define PCDB_CTRL_REPEAT  5
`define PCDB_CTRL_TX_EN   6
`define PCDB_CTRL_RX_EN   7
`define PCDB_CTRL_PKT     8
`define PCDB_CTRL_LVL_LO  16
`define PCDB_CTRL_LVL_HI  21
`define PCDB_CTRL_RESET   32'h0000_0101
`define PCDB_LEN_RESET    8'h10

// Status register fields
`define PCDB_ST_EMPTY     0
`define PCDB_ST_FULL      1
`define PCDB_ST_LEVEL     2
`define PCDB_ST_OVF       3
`define PCDB_ST_PASS      4
`define PCDB_ST_AVAIL     5
`define PCDB_ST_CNT_LO    8

// Line shaping codes
`define PCDB_SHAPE_MANCH  2'h1
`define PCDB_SHAPE_WHITE  2'h2

// Checksum and whitening constants
`define PCDB_POLY_A       16'h1021
`define PCDB_SEED_A       16'h1D0F
`define PCDB_POLY_B       16'h8005
`define PCDB_SEED_B       16'hFFFF
`define PCDB_WHITE_SEED   9'h1FF

`endif

// ### pcdb_pkg.sv
`include "pcdb_defines.svh"

package pcdb_pkg;

	typedef struct packed {
		logic       crc_en;
		logic       flush_dis;
		logic       variant;
		logic [1:0] shape;
		logic       repeat_en;
		logic       tx_en;
		logic       rx_en;
		logic       pkt_mode;
		logic [5:0] lvl;
	} pcdb_cfg_s;

	typedef enum logic [1:0] {
		PCDB_IDLE = 2'h0,
		PCDB_TX   = 2'h1,
		PCDB_RX   = 2'h3,
		PCDB_END  = 2'h2
	} pcdb_state_e;

endpackage

// ### pcdb_code_engine.sv
`include "pcdb_defines.svh"

module pcdb_code_engine
	import pcdb_pkg::*;
(
	// Clock, reset and enable
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Control
	input  wire logic        init,
	input  wire logic        variant,
	input  wire logic        step,
	input  wire logic        crc_step,
	input  wire logic        data_bit,
	// Results
	output logic      [15:0] crc_q,
	output logic      [15:0] crc_d,
	output logic      [8:0]  lfsr_q,
	output logic             white_bit
);

	logic fb;

	always_comb
	begin
		fb    = crc_q[15] ^ data_bit;
		crc_d = {crc_q[14:0], 1'b0} ^ (fb ? (variant ? `PCDB_POLY_B : `PCDB_POLY_A) : 16'h0000);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			crc_q <= `PCDB_SEED_A;
		else if (ce && init)
			crc_q <= variant ? `PCDB_SEED_B : `PCDB_SEED_A; // see RQ22
		else if (ce && step && crc_step)
			crc_q <= crc_d;
	end

	// Taps at x^9 and x^5
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			lfsr_q <= `PCDB_WHITE_SEED;
		else if (ce && init)
			lfsr_q <= `PCDB_WHITE_SEED; // see RQ21
		else if (ce && step)
			lfsr_q <= {lfsr_q[0] ^ lfsr_q[5], lfsr_q[8:1]}; // see RQ14
	end

	assign white_bit = lfsr_q[0];

	a_seed_load: assert property (@(posedge sys_clk) disable iff (rst) // see RQ22
		(ce && init) |=> crc_q == ($past(variant) ? `PCDB_SEED_B : `PCDB_SEED_A)
			&& lfsr_q == `PCDB_WHITE_SEED)
		else $error("seeds not loaded at packet start");

	a_lfsr_step: assert property (@(posedge sys_clk) disable iff (rst) // see RQ14
		(ce && step && !init) |=> lfsr_q[8] == ($past(lfsr_q[0]) ^ $past(lfsr_q[5]))
			&& lfsr_q[7:0] == $past(lfsr_q[8:1]))
		else $error("whitening register stepped wrongly");

endmodule // pcdb_code_engine

// ### pcdb_radio_model.sv
module pcdb_radio_model
	import pcdb_pkg::*;
#(
	parameter int TICK = 3
)(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Transmit side
	output logic      chip_tick,
	output logic      tx_start,
	input  wire logic tx_chip,
	input  wire logic tx_chip_valid,
	// Receive side
	output logic      rx_start,
	output logic      rx_chip,
	output logic      rx_chip_valid
);
	timeunit 1ns;
	timeprecision 1ps;

	int cnt;
	bit cap_q[$];

	initial
	begin
		tx_start      = 1'b0;
		rx_start      = 1'b0;
		rx_chip       = 1'b0;
		rx_chip_valid = 1'b0;
	end

	// Free-running divider, as a real bit-rate generator would be
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt       <= 0;
			chip_tick <= 1'b0;
		end
		else
		begin
			cnt       <= (cnt == TICK - 1) ? 0 : cnt + 1;
			chip_tick <= (cnt == TICK - 1);
		end
	end

	always @(posedge sys_clk)
	begin
		if (tx_chip_valid === 1'b1)
			cap_q.push_back(tx_chip);
	end

	task automatic start_tx();
		@(posedge sys_clk);
		tx_start <= 1'b1;
		@(posedge sys_clk);
		tx_start <= 1'b0;
	endtask

	// Line is not held between strobes: show the inverse of the last chip
	task automatic send_rx(input bit c[$]);
		@(posedge sys_clk);
		rx_start <= 1'b1;
		@(posedge sys_clk);
		rx_start <= 1'b0;
		foreach (c[i])
		begin
			repeat (2) @(posedge sys_clk);
			rx_chip       <= c[i];
			rx_chip_valid <= 1'b1;
			@(posedge sys_clk);
			rx_chip       <= ~c[i];
			rx_chip_valid <= 1'b0;
		end
	endtask
endmodule // pcdb_radio_model

// ### pcdb_framer_tb.sv
module pcdb_framer_tb
	import pcdb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk  = 1'b0;
	logic        rst      = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i  = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, rd;
	logic        wb_ack_o, chip_tick, tx_start, tx_chip, tx_chip_valid, tx_done;
	logic        rx_start, rx_chip, rx_chip_valid, irq;
	int          failures    = 0;
	int          comparisons = 0;
	int          cycles      = 0;
	logic [7:0]  pay[$];
	bit          chips[$];

	always #2 sys_clk = ~sys_clk;

	pcdb_framer #(.DEPTH(64), .AW(6)) dut_u (
		.sys_clk(sys_clk), .rst(rst), .ce(1'b1),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.chip_tick(chip_tick), .tx_start(tx_start), .tx_chip(tx_chip),
		.tx_chip_valid(tx_chip_valid), .tx_done(tx_done), .rx_start(rx_start),
		.rx_chip(rx_chip), .rx_chip_valid(rx_chip_valid), .payload_available_irq(irq));

	pcdb_radio_model #(.TICK(3)) radio_u (
		.sys_clk(sys_clk), .rst(rst), .chip_tick(chip_tick), .tx_start(tx_start),
		.tx_chip(tx_chip), .tx_chip_valid(tx_chip_valid), .rx_start(rx_start),
		.rx_chip(rx_chip), .rx_chip_valid(rx_chip_valid));

	task automatic wrap_up();
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do
		begin
			@(posedge sys_clk);
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	function automatic logic [31:0] st(input logic [6:0] c, input logic ovf, avail, pass);
		return {17'h0, c, 2'h0, avail, pass, ovf, c != 7'h00, c == 7'h40, c == 7'h00};
	endfunction

	// Reference chip stream for pay: checksum on plain bits, then shaping
	task automatic build(input bit vr, input bit crc_on, input logic [1:0] shp, input bit bad);
		logic [15:0] crc;
		logic [8:0]  lf;
		logic [7:0]  by[$];
		logic        b;
		crc   = vr ? 16'hFFFF : 16'h1D0F;
		lf    = 9'h1FF;
		by    = pay;
		chips = {};
		foreach (pay[i])
			for (int k = 7; k >= 0; k--)
			begin
				b   = crc[15] ^ pay[i][k];
				crc = {crc[14:0], 1'b0} ^ (b ? (vr ? 16'h8005 : 16'h1021) : 16'h0000);
			end
		if (!vr)
			crc = ~crc;
		crc[0] = crc[0] ^ bad;
		if (crc_on)
			by = {by, crc[15:8], crc[7:0]};
		foreach (by[i])
			for (int k = 7; k >= 0; k--)
			begin
				b  = by[i][k] ^ (shp == 2'h2 && lf[0]);
				lf = {lf[0] ^ lf[5], lf[8:1]};
				chips.push_back(b);
				if (shp == 2'h1)
					chips.push_back(!b);
			end
	endtask

	task automatic tx_run(input logic [31:0] ctl);
		build(ctl[2], ctl[0], ctl[4:3], 1'b0);
		xfer(1'b1, 8'h04, 32'(pay.size()));
		foreach (pay[i])
			xfer(1'b1, 8'h08, {24'h0, pay[i]});
		xfer(1'b1, 8'h00, ctl);
		radio_u.cap_q = {};
		radio_u.start_tx();
		while (tx_done !== 1'b1)
		begin
			@(posedge sys_clk);
		end
		@(posedge sys_clk);
		chk("chip count", 32'(chips.size()), 32'(radio_u.cap_q.size()));
		foreach (chips[i])
			if (i < radio_u.cap_q.size())
				chk("tx chip", 32'(chips[i]), 32'(radio_u.cap_q[i]));
	endtask

	task automatic rx_run(input logic [31:0] ctl, input bit bad);
		bit keep;
		keep = !bad || ctl[1];
		build(ctl[2], ctl[0], ctl[4:3], bad);
		xfer(1'b1, 8'h0C, 32'h0000_0028);
		xfer(1'b1, 8'h00, ctl);
		radio_u.send_rx(chips);
		repeat (3) @(posedge sys_clk);
		chk("irq", 32'(keep), 32'(irq));
		xfer(1'b0, 8'h0C, 32'h0);
		chk("rx status", st(keep ? 7'h03 : 7'h00, 1'b0, keep, !bad), rd & 32'h7F3F);
		if (keep)
			foreach (pay[i])
			begin
				xfer(1'b0, 8'h08, 32'h0);
				chk("rx byte", {24'h0, pay[i]}, rd & 32'h0000_00FF);
			end
	endtask

	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		xfer(1'b0, 8'h00, 32'h0);
		chk("ctrl reset", 32'h0000_0101, rd);
		xfer(1'b0, 8'h04, 32'h0);
		chk("len reset", 32'h0000_0010, rd);
		xfer(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h0, rd);
		xfer(1'b0, 8'h0C, 32'h0);
		chk("status reset", st(7'h00, 1'b0, 1'b0, 1'b0), rd & 32'h7F2F);
		pay = '{8'hA5, 8'h3C, 8'h00};
		tx_run(32'h0000_0159);
		tx_run(32'h0000_0145);
		tx_run(32'h0000_0149);
		tx_run(32'h0000_0155);
		tx_run(32'h0000_0158);
		rx_run(32'h0000_0189, 1'b0);
		rx_run(32'h0000_0198, 1'b0);
		rx_run(32'h0000_0195, 1'b1);
		rx_run(32'h0000_019B, 1'b1);
		// Queue depth: the 65th push must be dropped
		xfer(1'b1, 8'h00, 32'h0000_0100);
		xfer(1'b1, 8'h0C, 32'h0000_0028);
		for (int i = 0; i < 65; i++)
			xfer(1'b1, 8'h08, 32'(i));
		xfer(1'b0, 8'h0C, 32'h0);
		chk("fill status", st(7'h40, 1'b1, 1'b0, 1'b0), rd & 32'h7F2F);
		xfer(1'b1, 8'h0C, 32'h0000_0008);
		pay = '{8'h5A, 8'hC3};
		tx_run(32'h0000_0161);
		xfer(1'b0, 8'h0C, 32'h0);
		chk("sent status", st(7'h00, 1'b0, 1'b0, 1'b0), rd & 32'h7F2F);
		xfer(1'b1, 8'h00, 32'h0000_0121);
		xfer(1'b0, 8'h0C, 32'h0);
		chk("restored status", st(7'h02, 1'b0, 1'b0, 1'b0), rd & 32'h7F2F);
		xfer(1'b0, 8'h08, 32'h0);
		chk("restored byte", 32'h0000_005A, rd & 32'h0000_00FF);
		xfer(1'b1, 8'h00, 32'h0000_0101);
		xfer(1'b1, 8'h0C, 32'h0000_0008);
		xfer(1'b0, 8'h0C, 32'h0);
		chk("exit status", st(7'h00, 1'b0, 1'b0, 1'b0), rd & 32'h7F2F);
		wrap_up();
	end
endmodule // pcdb_framer_tb
